// file: gpo_block.v
// General outputs under command and sixteen logic-driven outputs
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
`include "gpo_consts.vh"
module gpo_block #(
	parameter NPIN  = `NUM_GENERAL_PINS,
	parameter NLOG  = `NUM_LOGIC_OUTPUTS,
	parameter NGPI  = 16,
	parameter NRAIL = 16,
	parameter TICK_CYCLES = `TICK_CYCLES
)(
	input  wire            clk,
	input  wire            rst,
	input  wire [7:0]      addr,
	input  wire [31:0]     wdata,
	input  wire            wr,
	input  wire            rd,
	output reg  [31:0]     rdata_r,
	input  wire [NGPI-1:0] gpi_state,
	input  wire [NRAIL-1:0] rail_enable,
	input  wire [NRAIL-1:0] rail_status,
	input  wire [NRAIL-1:0] rail_event,
	input  wire [NGPI-1:0] gpi_clear_en,
	output reg  [NPIN-1:0] gpo_out_r,
	output reg  [NPIN-1:0] gpo_oe_r,
	output reg  [NLOG-1:0] logic_driven_output_out_r,
	output reg  [NLOG-1:0] logic_driven_output_oe_r
);
	localparam TERMS = 64;

	////////////////////////////////////////////////////////////////
	// Command-controlled general outputs
	reg  [6:0]  pin_sel_r;
	reg  [1:0]  pin_state_r [0:NPIN-1];
	integer     i;
	integer     j;
	integer     k;

	always @(posedge clk)
	begin
		if (rst)
		begin
			pin_sel_r <= 7'h00;
			for (i = 0; i < NPIN; i = i + 1)
				pin_state_r[i] <= `PIN_STATE_HIZ;
		end
		else if (wr && addr == `REG_PIN_SELECT)
			pin_sel_r <= wdata[6:0];
		else if (wr && addr == `REG_PIN_CONFIG && pin_sel_r < NPIN)
			pin_state_r[pin_sel_r] <= wdata[1:0];
	end

	always @(posedge clk)
	begin
		if (rst)
		begin
			gpo_out_r <= {NPIN{1'b0}};
			gpo_oe_r  <= {NPIN{1'b0}};
		end
		else
		begin
			for (j = 0; j < NPIN; j = j + 1)
			begin
				gpo_out_r[j] <= (pin_state_r[j] == `PIN_STATE_HIGH);
				gpo_oe_r[j]  <= (pin_state_r[j] == `PIN_STATE_LOW) ||
					(pin_state_r[j] == `PIN_STATE_HIGH);
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Latched rail statuses
	reg  [NRAIL-1:0] latch_r;
	wire             gpi_clear = |(gpi_state & gpi_clear_en);
	wire             sw_clear  = wr && addr == `REG_LATCH_CLEAR;

	always @(posedge clk)
	begin
		if (rst)
			latch_r <= {NRAIL{1'b0}};
		else if (sw_clear || gpi_clear)
			latch_r <= rail_event;
		else
			latch_r <= latch_r | rail_event;
	end

	////////////////////////////////////////////////////////////////
	// Millisecond tick divider
	reg  [31:0] div_r;
	reg         tick_r;

	always @(posedge clk)
	begin
		if (rst)
		begin
			div_r  <= 32'h0000_0000;
			tick_r <= 1'b0;
		end
		else if (div_r == TICK_CYCLES - 1)
		begin
			div_r  <= 32'h0000_0000;
			tick_r <= 1'b1;
		end
		else
		begin
			div_r  <= div_r + 32'h0000_0001;
			tick_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Builder configuration storage
	reg  [3:0]       bsel_r;
	reg  [TERMS-1:0] mask0_r [0:NLOG-1];
	reg  [TERMS-1:0] inv0_r  [0:NLOG-1];
	reg  [TERMS-1:0] mask1_r [0:NLOG-1];
	reg  [TERMS-1:0] inv1_r  [0:NLOG-1];
	reg  [31:0]      ctrl_r  [0:NLOG-1];

	function [TERMS-1:0] set_half;
		input [TERMS-1:0] old;
		input [31:0]      val;
		input             hi;
		begin
			set_half = hi ? {val, old[31:0]} : {old[63:32], val};
		end
	endfunction

	always @(posedge clk)
	begin
		if (rst)
		begin
			bsel_r <= 4'h0;
			for (k = 0; k < NLOG; k = k + 1)
			begin
				mask0_r[k] <= {TERMS{1'b0}};
				inv0_r[k]  <= {TERMS{1'b0}};
				mask1_r[k] <= {TERMS{1'b0}};
				inv1_r[k]  <= {TERMS{1'b0}};
				ctrl_r[k]  <= `CTRL_RESET;
			end
		end
		else if (wr)
		begin
			case (addr)
				`REG_BUILDER_SELECT: bsel_r <= wdata[3:0];
				`REG_PATH0_MASK_LO: mask0_r[bsel_r] <= set_half(mask0_r[bsel_r], wdata, 1'b0);
				`REG_PATH0_MASK_HI: mask0_r[bsel_r] <= set_half(mask0_r[bsel_r], wdata, 1'b1);
				`REG_PATH0_INV_LO:  inv0_r[bsel_r]  <= set_half(inv0_r[bsel_r], wdata, 1'b0);
				`REG_PATH0_INV_HI:  inv0_r[bsel_r]  <= set_half(inv0_r[bsel_r], wdata, 1'b1);
				`REG_PATH1_MASK_LO: mask1_r[bsel_r] <= set_half(mask1_r[bsel_r], wdata, 1'b0);
				`REG_PATH1_MASK_HI: mask1_r[bsel_r] <= set_half(mask1_r[bsel_r], wdata, 1'b1);
				`REG_PATH1_INV_LO:  inv1_r[bsel_r]  <= set_half(inv1_r[bsel_r], wdata, 1'b0);
				`REG_PATH1_INV_HI:  inv1_r[bsel_r]  <= set_half(inv1_r[bsel_r], wdata, 1'b1);
				`REG_BUILDER_CTRL:  ctrl_r[bsel_r]  <= wdata;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Builders: term vector is GENERAL_INPUT_PIN, logic outputs, rail enables, statuses
	wire [NLOG-1:0]  result;
	wire [NLOG-1:0]  b_out;
	wire [NLOG-1:0]  b_oe;
	wire [TERMS-1:0] terms = {latch_r | rail_status, rail_enable, result, gpi_state};

	genvar g;
	generate
		for (g = 0; g < NLOG; g = g + 1)
		begin : gen_builder
			logic_builder #(
				.TERMS (TERMS)
			) u_builder (
				.clk       (clk),
				.rst       (rst),
				.tick      (tick_r),
				.terms     (terms),
				.mask0     (mask0_r[g]),
				.inv0      (inv0_r[g]),
				.mask1     (mask1_r[g]),
				.inv1      (inv1_r[g]),
				.ctrl      (ctrl_r[g]),
				.result_r  (result[g]),
				.pin_out_r (b_out[g]),
				.pin_oe_r  (b_oe[g])
			);
		end
	endgenerate

	always @(posedge clk)
	begin
		if (rst)
		begin
			logic_driven_output_out_r <= {NLOG{1'b0}};
			logic_driven_output_oe_r  <= {NLOG{1'b0}};
		end
		else
		begin
			logic_driven_output_out_r <= b_out;
			logic_driven_output_oe_r  <= b_oe;
		end
	end

	////////////////////////////////////////////////////////////////
	// Read port: data in the cycle after the strobe, zero otherwise
	always @(posedge clk)
	begin
		if (rst || !rd)
			rdata_r <= 32'h0000_0000;
		else
		begin
			case (addr)
				`REG_PIN_SELECT:     rdata_r <= {25'h0, pin_sel_r};
				`REG_PIN_CONFIG:     rdata_r <= (pin_sel_r < NPIN) ?
					{30'h0, pin_state_r[pin_sel_r]} : 32'h0000_0000;
				`REG_BUILDER_SELECT: rdata_r <= {28'h0, bsel_r};
				`REG_PATH0_MASK_LO:  rdata_r <= mask0_r[bsel_r][31:0];
				`REG_PATH0_MASK_HI:  rdata_r <= mask0_r[bsel_r][63:32];
				`REG_PATH0_INV_LO:   rdata_r <= inv0_r[bsel_r][31:0];
				`REG_PATH0_INV_HI:   rdata_r <= inv0_r[bsel_r][63:32];
				`REG_PATH1_MASK_LO:  rdata_r <= mask1_r[bsel_r][31:0];
				`REG_PATH1_MASK_HI:  rdata_r <= mask1_r[bsel_r][63:32];
				`REG_PATH1_INV_LO:   rdata_r <= inv1_r[bsel_r][31:0];
				`REG_PATH1_INV_HI:   rdata_r <= inv1_r[bsel_r][63:32];
				`REG_BUILDER_CTRL:   rdata_r <= ctrl_r[bsel_r];
				`REG_LOGIC_STATE:    rdata_r <= {16'h0, result};
				`REG_LATCH_STATE:    rdata_r <= {16'h0, latch_r};
				default:             rdata_r <= 32'h0000_0000;
			endcase
		end
	end
endmodule

// file: gpo_consts.vh
// Constants for the general output and logic-driven output block
`ifndef GPO_CONSTS_VH
`define GPO_CONSTS_VH

`define NUM_GENERAL_PINS     84
`define NUM_LOGIC_OUTPUTS    16
`define CLK_FREQ_HZ          40000000
`define TICK_PERIOD_MS       1
`define TICK_CYCLES          ((`CLK_FREQ_HZ / 1000) * `TICK_PERIOD_MS)

// Register map (word offsets on the plain port)
`define REG_PIN_SELECT       8'h00
`define REG_PIN_CONFIG       8'h01
`define REG_LATCH_CLEAR      8'h02
`define REG_BUILDER_SELECT   8'h03
`define REG_PATH0_MASK_LO    8'h04
`define REG_PATH0_MASK_HI    8'h05
`define REG_PATH0_INV_LO     8'h06
`define REG_PATH0_INV_HI     8'h07
`define REG_PATH1_MASK_LO    8'h08
`define REG_PATH1_MASK_HI    8'h09
`define REG_PATH1_INV_LO     8'h0A
`define REG_PATH1_INV_HI     8'h0B
`define REG_BUILDER_CTRL     8'h0C
`define REG_LOGIC_STATE      8'h0D
`define REG_LATCH_STATE      8'h0E

// Pin configure field: state codes
`define PIN_STATE_LOW        2'h0
`define PIN_STATE_HIGH       2'h1
`define PIN_STATE_HIZ        2'h2

// Builder control fields
`define CTRL_GATE_LSB        0
`define CTRL_POL_BIT         2
`define CTRL_OD_BIT          3
`define CTRL_DLY_ASSERT_BIT  4
`define CTRL_DLY_DEASSERT_BIT 5
`define CTRL_IGNORE_BIT      6
`define CTRL_DELAY_LSB       16

// Gate codes
`define GATE_AND             2'h0
`define GATE_OR              2'h1
`define GATE_NOR             2'h2

`define CTRL_RESET           32'h0000_0004
`endif

// file: logic_builder.v
// One Boolean logic builder with delay, polarity and drive mode
`timescale 1ns/1ps
`include "gpo_consts.vh"
module logic_builder #(
	parameter TERMS = 64
)(
	input  wire             clk,
	input  wire             rst,
	input  wire             tick,
	input  wire [TERMS-1:0] terms,
	input  wire [TERMS-1:0] mask0,
	input  wire [TERMS-1:0] inv0,
	input  wire [TERMS-1:0] mask1,
	input  wire [TERMS-1:0] inv1,
	input  wire [31:0]      ctrl,
	output reg              result_r,
	output reg              pin_out_r,
	output reg              pin_oe_r
);
	localparam ST_IDLE  = 2'b01;
	localparam ST_DELAY = 2'b10;

	reg  [1:0]  state_r;
	reg  [15:0] count_r;
	reg         target_r;
	wire        path0;
	wire        path1;
	reg         gate;
	wire [1:0]  gate_sel = ctrl[`CTRL_GATE_LSB+1:`CTRL_GATE_LSB];
	wire [15:0] delay_ms = ctrl[`CTRL_DELAY_LSB+15:`CTRL_DELAY_LSB];
	wire        ignore   = ctrl[`CTRL_IGNORE_BIT];
	wire        need_dly;
	wire        level;

	// Unselected terms read as true; empty path is true
	assign path0 = &((terms ^ inv0) | ~mask0);
	assign path1 = &((terms ^ inv1) | ~mask1);

	always @*
	begin
		case (gate_sel)
			`GATE_AND: gate = path0 & path1;
			`GATE_OR:  gate = path0 | path1;
			`GATE_NOR: gate = ~(path0 | path1);
			default:   gate = path0 & path1;
		endcase
	end

	assign need_dly = (delay_ms != 16'h0000) &&
		(gate ? ctrl[`CTRL_DLY_ASSERT_BIT] : ctrl[`CTRL_DLY_DEASSERT_BIT]);

	always @(posedge clk)
	begin
		if (rst)
		begin
			state_r  <= ST_IDLE;
			count_r  <= 16'h0000;
			target_r <= 1'b0;
			result_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				ST_IDLE:
				begin
					if (gate != result_r)
					begin
						if (need_dly)
						begin
							state_r  <= ST_DELAY;
							count_r  <= delay_ms;
							target_r <= gate;
						end
						else
							result_r <= gate;
					end
				end
				ST_DELAY:
				begin
					if (!ignore && gate != target_r)
						state_r <= ST_IDLE;
					else if (tick)
					begin
						if (count_r == 16'h0001)
						begin
							result_r <= target_r;
							state_r  <= ST_IDLE;
						end
						count_r <= count_r - 16'h0001;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	assign level = ctrl[`CTRL_POL_BIT] ? result_r : ~result_r;

	always @(posedge clk)
	begin
		if (rst)
		begin
			pin_out_r <= 1'b0;
			pin_oe_r  <= 1'b0;
		end
		else
		begin
			pin_out_r <= ctrl[`CTRL_OD_BIT] ? 1'b0 : level;
			pin_oe_r  <= ctrl[`CTRL_OD_BIT] ? ~level : 1'b1;
		end
	end
endmodule

// file: gpo_block_props.sv
// Checker for the command and logic-driven output block
`timescale 1ns/1ps
module gpo_block_props #(
	parameter NPIN  = 84,
	parameter NLOG  = 16,
	parameter NGPI  = 16,
	parameter NRAIL = 16
)(
	input wire		clk,
	input wire		rst,
	input wire	[7:0]	addr,
	input wire	[31:0]	wdata,
	input wire		wr,
	input wire		rd,
	input wire	[31:0]	rdata_r,
	input wire	[NGPI-1:0]	gpi_state,
	input wire	[NRAIL-1:0]	rail_event,
	input wire	[NGPI-1:0]	gpi_clear_en,
	input wire	[NPIN-1:0]	gpo_out_r,
	input wire	[NPIN-1:0]	gpo_oe_r,
	input wire	[NLOG-1:0]	logic_driven_output_out_r,
	input wire	[NLOG-1:0]	logic_driven_output_oe_r
);
	reg	[31:0]	sel_r;
	reg	[NRAIL-1:0]	lat_r;
	wire		clr = (wr && addr == 8'h02) || |(gpi_state & gpi_clear_en);
	wire		cfg = wr && addr == 8'h01;
	// Mirrors of pin select and sticky status
	always @(posedge clk)
	begin
		if (wr && addr == 8'h00)
			sel_r <= wdata;
		lat_r <= rst ? '0 : ((clr ? '0 : lat_r) | rail_event);
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_rdata_idle: assert property (!$past(rd) |-> rdata_r == 32'h0)
		else $error("read data outside answer cycle");
	a_unmapped_zero: assert property (rd && addr > 8'h0E |=> rdata_r == 32'h0)
		else $error("unmapped read not zero");
	a_pin_drive: assert property (cfg && sel_r < NPIN && !wdata[1] |-> ##2
		gpo_oe_r[sel_r] && gpo_out_r[sel_r] == $past(wdata[0], 2))
		else $error("command pin not driven");
	a_pin_float: assert property (cfg && sel_r < NPIN && wdata[1] |-> ##2 !gpo_oe_r[sel_r])
		else $error("command pin not released");
	a_bad_pin: assert property (cfg && sel_r >= NPIN |-> ##2 gpo_oe_r == $past(gpo_oe_r, 2))
		else $error("absent pin configured");
	a_latch_read: assert property (rd && addr == 8'h0E |=> rdata_r[NRAIL-1:0] == $past(lat_r))
		else $error("latched status lost");
	a_od_release: assert property ((logic_driven_output_out_r & ~logic_driven_output_oe_r) == '0)
		else $error("high level driven in open drain");
	a_reset_out: assert property ($fell(rst) |-> gpo_oe_r == '0 ##[1:4]
		(&logic_driven_output_oe_r && &logic_driven_output_out_r))
		else $error("outputs wrong after reset");
	c_pin_float: cover property (cfg && wdata[1]);
	c_latch: cover property (rd && addr == 8'h0E && |lat_r);
	c_logic_driven_output_rise: cover property ($rose(logic_driven_output_out_r[0]));
endmodule

bind gpo_block gpo_block_props #(.NPIN(NPIN), .NLOG(NLOG), .NGPI(NGPI), .NRAIL(NRAIL)) props (
	.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r),
	.gpi_state(gpi_state), .rail_event(rail_event), .gpi_clear_en(gpi_clear_en),
	.gpo_out_r(gpo_out_r), .gpo_oe_r(gpo_oe_r), .logic_driven_output_out_r(logic_driven_output_out_r), .logic_driven_output_oe_r(logic_driven_output_oe_r));

// file: board_load.sv
// Loads on the output pins
`timescale 1ns/1ps
module board_load #(
	parameter W    = 16,
	parameter PULL = 1
)(
	input wire		clk,
	input wire	[W-1:0]	drv,
	input wire	[W-1:0]	oe,
	output wire	[W-1:0]	level
);
	reg	[W-1:0]	flt_r = '0;
	// Released line: pull-up, or flips every cycle
	assign level = (oe & drv) | (~oe & (PULL ? {W{1'b1}} : flt_r));
	always @(posedge clk)
		flt_r <= ~level;
endmodule

// file: boolean_logic_gpo_bench.sv
// Self-checking bench for the command and logic-driven output block
`timescale 1ns/1ps
module boolean_logic_gpo_bench;
	reg		clk, rst, wr, rd;
	reg	[7:0]	addr;
	reg	[31:0]	wdata, seed, v;
	reg	[15:0]	gpi_state, rail_enable, rail_status, rail_event, gpi_clear_en;
	wire	[31:0]	rdata_r;
	wire	[83:0]	gpo_out_r, gpo_oe_r, pin_lvl;
	wire	[15:0]	logic_driven_output_out_r, logic_driven_output_oe_r, led_lvl;
	reg	[83:0]	snap;
	integer		n_mismatch, n_compared, i, b, g, p, d, r, q0, q1;
	gpo_block #(.TICK_CYCLES(4)) DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata_r(rdata_r), .gpi_state(gpi_state),
		.rail_enable(rail_enable), .rail_status(rail_status), .rail_event(rail_event),
		.gpi_clear_en(gpi_clear_en), .gpo_out_r(gpo_out_r), .gpo_oe_r(gpo_oe_r),
		.logic_driven_output_out_r(logic_driven_output_out_r), .logic_driven_output_oe_r(logic_driven_output_oe_r));
	board_load #(.W(84), .PULL(0)) pins (.clk(clk), .drv(gpo_out_r), .oe(gpo_oe_r),
		.level(pin_lvl));
	board_load #(.W(16), .PULL(1)) leds (.clk(clk), .drv(logic_driven_output_out_r), .oe(logic_driven_output_oe_r),
		.level(led_lvl));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	function [31:0] xs(input [31:0] s);
		begin
			xs = s ^ (s << 13);
			xs = xs ^ (xs >> 17);
			xs = xs ^ (xs << 5);
		end
	endfunction
	task wr_reg(input [7:0] a, input [31:0] dt);
		begin
			@(posedge clk);
			wr <= 1'b1;
			addr <= a;
			wdata <= dt;
			@(posedge clk);
			wr <= 1'b0;
		end
	endtask
	task rd_reg(input [7:0] a);
		begin
			@(posedge clk);
			rd <= 1'b1;
			addr <= a;
			@(posedge clk);
			rd <= 1'b0;
			#1;
			v = rdata_r;
		end
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] s);
		begin
			n_compared = n_compared + 1;
			if (s !== e)
			begin
				n_mismatch = n_mismatch + 1;
				$display("wrong value %s expected %h seen %h", nm, e, s);
			end
		end
	endtask
	task wrap_up;
		begin
			if (n_mismatch == 0 && n_compared > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch = n_mismatch + 1;
		wrap_up;
	end
	initial
	begin
		{n_mismatch, n_compared, wr, rd, addr, wdata} = 0;
		{gpi_state, rail_enable, rail_status, rail_event, gpi_clear_en} = 0;
		seed = 32'hC99446F1;
		rst = 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
		#1;
		chk("gpo_oe", 0, {31'h0, |gpo_oe_r});
		chk("logic_driven_output", 32'h0000FFFF, {16'h0, led_lvl & logic_driven_output_oe_r});
		for (i = 0; i < 9; i = i + 1)
		begin
			seed = xs(seed);
			p = (i == 0) ? 83 : seed % 84;
			r = i % 3;
			wr_reg(8'h00, p);
			wr_reg(8'h01, r);
			@(posedge clk);
			#1;
			chk("pin_oe", (r < 2) ? 1 : 0, {31'h0, gpo_oe_r[p]});
			if (r < 2)
				chk("pin_lvl", r, {31'h0, pin_lvl[p]});
		end
		snap = gpo_oe_r;
		wr_reg(8'h00, 84);
		wr_reg(8'h01, 0);
		repeat (2) @(posedge clk);
		#1;
		chk("bad_pin", 0, {31'h0, |(snap ^ gpo_oe_r)});
		for (i = 0; i < 12; i = i + 1)
		begin
			seed = xs(seed);
			b = seed % 16;
			g = i % 4;
			p = seed[8];
			d = seed[9];
			wr_reg(8'h03, b);
			wr_reg(8'h04, 1);
			wr_reg(8'h06, seed[10]);
			wr_reg(8'h08, 2);
			wr_reg(8'h0A, {seed[11], 1'b0});
			wr_reg(8'h0C, g | (p << 2) | (d << 3));
			gpi_state <= seed[31:16];
			rail_enable <= seed[15:0];
			rail_status <= ~seed[15:0];
			repeat (4) @(posedge clk);
			q0 = seed[16] ^ seed[10];
			q1 = seed[17] ^ seed[11];
			r = (g == 1) ? (q0 | q1) : (g == 2) ? !(q0 | q1) : (q0 & q1);
			rd_reg(8'h0D);
			chk("result", r, {31'h0, v[b]});
			chk("logic_driven_output_lvl", p ? r : !r, {31'h0, led_lvl[b]});
			chk("logic_driven_output_oe", d ? (p ? !r : r) : 1, {31'h0, logic_driven_output_oe_r[b]});
		end
		gpi_state <= 16'h0000;
		wr_reg(8'h03, 5);
		wr_reg(8'h04, 1);
		wr_reg(8'h06, 0);
		wr_reg(8'h08, 0);
		wr_reg(8'h0C, 32'h00020014);
		repeat (4) @(posedge clk);
		gpi_state <= 16'h0001;
		repeat (3) @(posedge clk);
		#1;
		chk("delay_hold", 0, {31'h0, led_lvl[5]});
		repeat (12) @(posedge clk);
		#1;
		chk("delay_done", 1, {31'h0, led_lvl[5]});
		gpi_state <= 16'hFFFE;
		repeat (4) @(posedge clk);
		#1;
		chk("no_deassert_dly", 0, {31'h0, led_lvl[5]});
		// Short input pulse: aborted without ignore, completed with it
		for (i = 0; i < 2; i = i + 1)
		begin
			wr_reg(8'h0C, i ? 32'h00020054 : 32'h00020014);
			gpi_state <= 16'hFFFF;
			repeat (2) @(posedge clk);
			gpi_state <= 16'hFFFE;
			q0 = 0;
			repeat (24)
			begin
				@(posedge clk);
				#1;
				if (led_lvl[5])
					q0 = 1;
			end
			chk("ignore_dly", i, q0);
		end
		for (i = 0; i < 3; i = i + 1)
		begin
			seed = xs(seed);
			@(posedge clk);
			rail_event <= seed[15:0] | 16'h0001;
			@(posedge clk);
			rail_event <= 16'h0000;
			if (i == 1)
				wr_reg(8'h02, 0);
			if (i == 2)
				gpi_clear_en <= 16'h0002;
			@(posedge clk);
			gpi_clear_en <= 16'h0000;
			rd_reg(8'h0E);
			chk("latch", i ? 0 : seed[15:0] | 1, {16'h0, v[15:0]});
		end
		rd_reg(8'h3F);
		chk("unmapped", 0, v);
		wrap_up;
	end
endmodule
